// file: pmic_cfg_pkg.sv
// Constants, register layout and carrier types for the configuration slice
// Behaviour
// RULE1: Push-button hold is 8 s when hold field is 0, 15 s when 1.
// RULE2: Output 2 is open-drain when drive field is 0, push-pull when 1.
// RULE3: Pin-1 role 0: pin 1 open-drain output, output 2 independent.
// RULE4: Pin-1 role 1: pin 1 is an input that drives output 2.
// RULE5: Power-good delay 10, 20, 50 or 150 ms from the two-bit field.
// RULE6: Delay applies only to power-good rising; falling is immediate.
// RULE7: Strictness 0: wide falling limits, no overvoltage monitoring.
// RULE8: Strictness 1: tight falling limits and overvoltage is flagged.
// RULE9: Warm-reset enable 0: pin 3 is a general-purpose output.
// RULE10: Warm-reset enable 1: pin 3 is warm-reset input for bucks 1 and 2.
// RULE11: Switch 3 limit codes give 100, 200, 500 or 1000 mA.
// RULE12: Switch 2 limit codes give 100, 200, 500 or 1000 mA.
// RULE13: Writes here need a prior unlock through the password register.
// RULE14: With warm-reset enabled, the pin 3 level bit is ignored.
// RULE15: With pin-1 role set, pin 1 and output 2 level bits are ignored.
// RULE16: Reserved bits read zero and ignore writes.
package pmic_cfg_pkg;

	localparam logic [7:0] ADDR_PASSWORD = 8'h10;
	localparam logic [7:0] ADDR_CONFIG_A = 8'h13;
	localparam logic [7:0] ADDR_CONFIG_B = 8'h14;
	localparam logic [7:0] ADDR_CONFIG_C = 8'h15;

	localparam logic [7:0] RESET_CONFIG_A = 8'h00;
	localparam logic [7:0] RESET_CONFIG_B = 8'h40;
	localparam logic [7:0] RESET_CONFIG_C = 8'h00;

	// Writable bit masks; the rest is reserved
	localparam logic [7:0] MASK_CONFIG_A = 8'hFF;
	localparam logic [7:0] MASK_CONFIG_B = 8'hCF;
	localparam logic [7:0] MASK_CONFIG_C = 8'h3F;

	// Unlock key: arbitrary value, combined with the target subaddress
	localparam logic [7:0] UNLOCK_KEY = 8'hA5;

	localparam int unsigned CLK_PERIOD_NS = 25;
	localparam int unsigned MS_NS = 1000000;
	localparam int unsigned MS_CYCLES =
		(MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned MS_PER_S = 1000;

	localparam logic [13:0] HOLD_SHORT_MS = 14'(8 * MS_PER_S);
	localparam logic [13:0] HOLD_LONG_MS = 14'(15 * MS_PER_S);
	localparam logic [13:0] GOOD_DELAY0_MS = 14'(10);
	localparam logic [13:0] GOOD_DELAY1_MS = 14'(20);
	localparam logic [13:0] GOOD_DELAY2_MS = 14'(50);
	localparam logic [13:0] GOOD_DELAY3_MS = 14'(150);

	localparam logic [10:0] LIMIT0_MA = 11'h064;
	localparam logic [10:0] LIMIT1_MA = 11'h0C8;
	localparam logic [10:0] LIMIT2_MA = 11'h1F4;
	localparam logic [10:0] LIMIT3_MA = 11'h3E8;

	typedef struct packed {
		logic       hold_long_sel;
		logic       output2_drive_type;
		logic       pin1_role_sel;
		logic [1:0] good_delay_sel;
		logic       supervisor_tight_sel;
		logic [1:0] undervolt_sel;
	} config_a_type;

	typedef struct packed {
		logic       warm_reset_pin_en;
		logic       undervolt_hyst_sel;
		logic [1:0] reserved;
		logic [1:0] switch3_limit_sel;
		logic [1:0] switch2_limit_sel;
	} config_b_type;

	typedef struct packed {
		logic       wr_en;
		logic       rd_en;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_type;

	typedef enum logic [2:0] {
		PG_LOW  = 3'b001,
		PG_WAIT = 3'b010,
		PG_HIGH = 3'b100
	} good_state_type;

endpackage

// file: ms_timer.sv
// Millisecond timer with its own cycle prescaler, restarted by run
`timescale 1ns/10ps
module ms_timer #(
	parameter int unsigned TICK_CYCLES = pmic_cfg_pkg::MS_CYCLES
) (
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic        run,
	input  wire logic [13:0] limit_ms,
	output logic             expired
);
	logic [15:0] prescale_reg;
	logic [13:0] ms_reg;
	logic        ms_tick;

	assign ms_tick = run && (prescale_reg == 16'(TICK_CYCLES - 1));
	assign expired = run && (ms_reg >= limit_ms);

	// Restarting on run keeps the delay exact instead of off by a tick
	always_ff @(posedge clk) begin
		if (!rst_b || !run || ms_tick)
			prescale_reg <= 16'h0000;
		else
			prescale_reg <= prescale_reg + 16'h0001;
	end

	always_ff @(posedge clk) begin
		if (!rst_b || !run)
			ms_reg <= 14'h0000;
		else if (ms_tick && !expired)
			ms_reg <= ms_reg + 14'h0001;
	end
endmodule

// file: pmic_config_registers.sv
// Configuration registers 0x13-0x15 and the pin, delay and limit logic
`timescale 1ns/10ps
module pmic_config_registers #(
	parameter int unsigned MS_TICK_CYCLES = pmic_cfg_pkg::MS_CYCLES
) (
	input  wire logic                      clk,
	input  wire logic                      rst_b,
	input  wire pmic_cfg_pkg::reg_req_type reg_req,
	output logic [7:0]                     rd_data,
	output logic                           write_rejected,
	input  wire logic [2:0]                level_bits,
	input  wire logic                      general_pin_first_in,
	output logic                           general_pin_first_out,
	output logic                           general_pin_first_oe,
	output logic                           general_out_second_out,
	output logic                           general_out_second_oe,
	output logic                           out2_high_from_switch_supply,
	input  wire logic                      general_pin_third_in,
	output logic                           general_pin_third_out,
	output logic                           general_pin_third_oe,
	output logic                           buck_warm_reset,
	input  wire logic                      button_held,
	output logic                           button_reset,
	input  wire logic                      rails_good,
	output logic                           power_good,
	output logic                           tight_limits_en,
	output logic                           overvoltage_monitor_en,
	input  wire logic                      rail_overvoltage,
	output logic                           overvoltage_flag,
	output logic [10:0]                    switch3_limit_ma,
	output logic [10:0]                    switch2_limit_ma,
	output logic [5:0]                     switch_misc_cfg,
	output logic [1:0]                     undervolt_sel,
	output logic                           undervolt_hyst_sel
);
	pmic_cfg_pkg::config_a_type   cfg_a_reg;
	pmic_cfg_pkg::config_b_type   cfg_b_reg;
	logic [7:0]                   cfg_c_reg;
	logic                         unlock_reg;
	logic [7:0]                   unlock_addr_reg;
	logic                         button_fired_reg;
	pmic_cfg_pkg::good_state_type good_state_reg;
	pmic_cfg_pkg::good_state_type good_state_next;
	logic                         protected_hit;
	logic                         write_ok;
	logic                         good_expired;
	logic                         hold_expired;
	logic [13:0]                  good_limit_ms;
	logic [13:0]                  hold_limit_ms;

	function automatic logic [10:0] limit_ma(input logic [1:0] code);
		unique case (code)
			2'b00: limit_ma = pmic_cfg_pkg::LIMIT0_MA;
			2'b01: limit_ma = pmic_cfg_pkg::LIMIT1_MA;
			2'b10: limit_ma = pmic_cfg_pkg::LIMIT2_MA;
			2'b11: limit_ma = pmic_cfg_pkg::LIMIT3_MA;
		endcase
	endfunction

	// Register writes
	assign protected_hit = reg_req.addr == pmic_cfg_pkg::ADDR_CONFIG_A ||
		reg_req.addr == pmic_cfg_pkg::ADDR_CONFIG_B ||
		reg_req.addr == pmic_cfg_pkg::ADDR_CONFIG_C;
	assign write_ok = reg_req.wr_en && protected_hit && unlock_reg &&
		reg_req.addr == unlock_addr_reg; // RULE13

	// Unlock covers exactly one following write; any other write cancels it
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			unlock_reg      <= 1'b0;
			unlock_addr_reg <= 8'h00;
		end else if (reg_req.wr_en) begin
			unlock_reg      <= reg_req.addr == pmic_cfg_pkg::ADDR_PASSWORD;
			unlock_addr_reg <= reg_req.wdata ^ pmic_cfg_pkg::UNLOCK_KEY;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b)
			write_rejected <= 1'b0;
		else
			write_rejected <= reg_req.wr_en && protected_hit &&
				!write_ok; // RULE13
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			cfg_a_reg <= pmic_cfg_pkg::RESET_CONFIG_A;
			cfg_b_reg <= pmic_cfg_pkg::RESET_CONFIG_B;
			cfg_c_reg <= pmic_cfg_pkg::RESET_CONFIG_C;
		end else if (write_ok) begin
			if (reg_req.addr == pmic_cfg_pkg::ADDR_CONFIG_A)
				cfg_a_reg <= reg_req.wdata & pmic_cfg_pkg::MASK_CONFIG_A;
			if (reg_req.addr == pmic_cfg_pkg::ADDR_CONFIG_B)
				cfg_b_reg <= reg_req.wdata &
					pmic_cfg_pkg::MASK_CONFIG_B; // RULE16
			if (reg_req.addr == pmic_cfg_pkg::ADDR_CONFIG_C)
				cfg_c_reg <= reg_req.wdata &
					pmic_cfg_pkg::MASK_CONFIG_C; // RULE16
		end
	end

	// Reads: one cycle latency; password and unmapped read zero
	always_ff @(posedge clk) begin
		if (!rst_b)
			rd_data <= 8'h00;
		else if (reg_req.rd_en) begin
			unique case (reg_req.addr)
				pmic_cfg_pkg::ADDR_CONFIG_A: rd_data <= cfg_a_reg;
				pmic_cfg_pkg::ADDR_CONFIG_B: rd_data <= cfg_b_reg;
				pmic_cfg_pkg::ADDR_CONFIG_C: rd_data <= cfg_c_reg;
				default:                     rd_data <= 8'h00;
			endcase
		end
	end

	// General pins; open-drain means driving only while low
	always_comb begin
		general_pin_first_out = 1'b0;
		general_pin_first_oe  = !cfg_a_reg.pin1_role_sel &&
			!level_bits[0]; // RULE3 RULE15
		general_out_second_out = cfg_a_reg.pin1_role_sel ?
			general_pin_first_in : level_bits[1]; // RULE4 RULE15
		if (cfg_a_reg.output2_drive_type) // RULE2
			general_out_second_oe = 1'b1;
		else begin
			general_out_second_oe  = !general_out_second_out;
			general_out_second_out = 1'b0;
		end
		general_pin_third_out = 1'b0;
		general_pin_third_oe  = !cfg_b_reg.warm_reset_pin_en &&
			!level_bits[2]; // RULE9 RULE14
	end
	assign out2_high_from_switch_supply = cfg_a_reg.output2_drive_type;

	// Warm reset is active low on the pin
	assign buck_warm_reset = cfg_b_reg.warm_reset_pin_en &&
		!general_pin_third_in; // RULE10

	// Supervisor strictness
	assign tight_limits_en        = cfg_a_reg.supervisor_tight_sel; // RULE7
	assign overvoltage_monitor_en = cfg_a_reg.supervisor_tight_sel; // RULE8
	assign overvoltage_flag = cfg_a_reg.supervisor_tight_sel &&
		rail_overvoltage; // RULE8

	assign switch3_limit_ma = limit_ma(cfg_b_reg.switch3_limit_sel); // RULE11
	assign switch2_limit_ma = limit_ma(cfg_b_reg.switch2_limit_sel); // RULE12
	assign switch_misc_cfg    = cfg_c_reg[5:0];
	assign undervolt_sel      = cfg_a_reg.undervolt_sel;
	assign undervolt_hyst_sel = cfg_b_reg.undervolt_hyst_sel;

	// Push-button hold
	assign hold_limit_ms = cfg_a_reg.hold_long_sel ?
		pmic_cfg_pkg::HOLD_LONG_MS : pmic_cfg_pkg::HOLD_SHORT_MS; // RULE1

	ms_timer #(.TICK_CYCLES(MS_TICK_CYCLES)) hold_timer (
		.clk      (clk),
		.rst_b    (rst_b),
		.run      (button_held),
		.limit_ms (hold_limit_ms),
		.expired  (hold_expired)
	);

	// One reset pulse per press, however long it is held afterwards
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			button_fired_reg <= 1'b0;
			button_reset     <= 1'b0;
		end else begin
			button_reset     <= hold_expired && !button_fired_reg; // RULE1
			button_fired_reg <= button_held &&
				(button_fired_reg || hold_expired);
		end
	end

	// Power-good sequencing
	always_comb begin
		unique case (cfg_a_reg.good_delay_sel) // RULE5
			2'b00: good_limit_ms = pmic_cfg_pkg::GOOD_DELAY0_MS;
			2'b01: good_limit_ms = pmic_cfg_pkg::GOOD_DELAY1_MS;
			2'b10: good_limit_ms = pmic_cfg_pkg::GOOD_DELAY2_MS;
			2'b11: good_limit_ms = pmic_cfg_pkg::GOOD_DELAY3_MS;
		endcase
	end

	ms_timer #(.TICK_CYCLES(MS_TICK_CYCLES)) good_timer (
		.clk      (clk),
		.rst_b    (rst_b),
		.run      (good_state_reg == pmic_cfg_pkg::PG_WAIT),
		.limit_ms (good_limit_ms),
		.expired  (good_expired)
	);

	always_comb begin
		good_state_next = good_state_reg;
		unique case (good_state_reg)
			pmic_cfg_pkg::PG_LOW:
				if (rails_good)
					good_state_next = pmic_cfg_pkg::PG_WAIT;
			pmic_cfg_pkg::PG_WAIT:
				if (!rails_good)
					good_state_next = pmic_cfg_pkg::PG_LOW;
				else if (good_expired)
					good_state_next = pmic_cfg_pkg::PG_HIGH; // RULE5
			pmic_cfg_pkg::PG_HIGH:
				if (!rails_good)
					good_state_next = pmic_cfg_pkg::PG_LOW; // RULE6
			default:
				good_state_next = pmic_cfg_pkg::PG_LOW;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_b)
			good_state_reg <= pmic_cfg_pkg::PG_LOW;
		else
			good_state_reg <= good_state_next;
	end
	assign power_good = good_state_reg == pmic_cfg_pkg::PG_HIGH;

	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	sequence s_locked_write;
		reg_req.wr_en && protected_hit && !unlock_reg;
	endsequence

	property p_locked_write_rejected;
		s_locked_write |=> write_rejected && $stable(cfg_a_reg) &&
			$stable(cfg_b_reg) && $stable(cfg_c_reg);
	endproperty
	a_locked_write_rejected: assert property (p_locked_write_rejected) // RULE13
		else $error("protected write taken without unlock");

	property p_good_falls_at_once;
		power_good && !rails_good |=> !power_good;
	endproperty
	a_good_falls_at_once: assert property (p_good_falls_at_once) // RULE6
		else $error("power-good fall was delayed");

	property p_good_rise_after_delay;
		$rose(power_good) |-> $past(good_expired) && $past(rails_good);
	endproperty
	a_good_rise_after_delay: assert property (p_good_rise_after_delay) // RULE5
		else $error("power-good rose before its delay");

	property p_good_delay_value;
		cfg_a_reg.good_delay_sel == 2'b11 |->
			good_limit_ms == 14'(150);
	endproperty
	a_good_delay_value: assert property (p_good_delay_value) // RULE5
		else $error("wrong longest power-good delay");

	property p_out2_open_drain;
		!cfg_a_reg.output2_drive_type |-> !general_out_second_out;
	endproperty
	a_out2_open_drain: assert property (p_out2_open_drain) // RULE2
		else $error("open-drain output drove high");

	property p_pin1_controls_out2;
		cfg_a_reg.pin1_role_sel && cfg_a_reg.output2_drive_type |->
			general_out_second_out == general_pin_first_in &&
			!general_pin_first_oe;
	endproperty
	a_pin1_controls_out2: assert property (p_pin1_controls_out2) // RULE4
		else $error("pin 1 input does not steer output 2");

	property p_pin3_released;
		cfg_b_reg.warm_reset_pin_en |-> !general_pin_third_oe;
	endproperty
	a_pin3_released: assert property (p_pin3_released) // RULE14
		else $error("pin 3 driven while used as warm-reset input");

	property p_limit_top;
		cfg_b_reg.switch3_limit_sel == 2'b11 |-> switch3_limit_ma == 11'h3E8;
	endproperty
	a_limit_top: assert property (p_limit_top) // RULE11
		else $error("switch 3 top current limit wrong");

	property p_reserved_zero;
		reg_req.rd_en && reg_req.addr == pmic_cfg_pkg::ADDR_CONFIG_C |=>
			rd_data[7:6] == 2'b00;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) // RULE16
		else $error("reserved bits read nonzero");

	property p_overvoltage_gated;
		!cfg_a_reg.supervisor_tight_sel |-> !overvoltage_flag;
	endproperty
	a_overvoltage_gated: assert property (p_overvoltage_gated) // RULE7
		else $error("overvoltage flagged while not monitored");
endmodule

// file: host_model.sv
// Host-side requester that drives the serial engine's register requests
`timescale 1ns/10ps
module host_model (
	input  wire logic                 clk,
	output pmic_cfg_pkg::reg_req_type req
);
	initial req = '0;

	task automatic drive(input logic w, input logic [7:0] a,
		input logic [7:0] d);
		@(negedge clk);
		req = '{wr_en: w, rd_en: !w, addr: a, wdata: d};
		@(negedge clk);
		// Released fields show the inverse so a stale value is never trusted
		req = '{wr_en: 1'b0, rd_en: 1'b0, addr: ~a, wdata: ~d};
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		drive(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a);
		drive(1'b0, a, 8'h00);
	endtask

	task automatic unlock_wr(input logic [7:0] a, input logic [7:0] d);
		// Key write must be the last write before the protected one
		drive(1'b1, 8'h10, a ^ pmic_cfg_pkg::UNLOCK_KEY);
		drive(1'b1, a, d);
	endtask
endmodule

// file: testbench.sv
// Self-checking bench for the configuration register slice
`timescale 1ns/10ps
module testbench;
	localparam int T = 2;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	pmic_cfg_pkg::reg_req_type req;
	logic [7:0] rd_data, v, a;
	logic wrej, p1_out, p1_oe, o2_out, o2_oe, o2_hi, p3_out, p3_oe, warm;
	logic breset, pgood, tight, ovmon, ovflag, rd_flag = 1'b0;
	logic [10:0] lim3, lim2;
	logic [5:0] misc;
	logic [1:0] uv;
	logic uv_hys;
	logic [2:0] level_bits = 3'h7;
	logic pin1_in = 1'b1, pin3_in = 1'b1, button = 1'b0;
	logic rails = 1'b0, rail_ov = 1'b0;
	logic [7:0] exp_q[$];
	logic [10:0] lim_tab[4] = '{11'h064, 11'h0C8, 11'h1F4, 11'h3E8};
	int dly[4] = '{10, 20, 50, 150};
	int num_errors = 0, n_checks = 0, seed = 35, n;

	always #12.5 clk = ~clk;

	host_model host_model_inst (.clk(clk), .req(req));

	pmic_config_registers #(.MS_TICK_CYCLES(T)) pmic_config_registers_inst (
		.clk(clk), .rst_b(rst_b), .reg_req(req), .rd_data(rd_data),
		.write_rejected(wrej), .level_bits(level_bits),
		.general_pin_first_in(pin1_in), .general_pin_first_out(p1_out),
		.general_pin_first_oe(p1_oe), .general_out_second_out(o2_out),
		.general_out_second_oe(o2_oe), .out2_high_from_switch_supply(o2_hi),
		.general_pin_third_in(pin3_in), .general_pin_third_out(p3_out),
		.general_pin_third_oe(p3_oe), .buck_warm_reset(warm),
		.button_held(button), .button_reset(breset), .rails_good(rails),
		.power_good(pgood), .tight_limits_en(tight),
		.overvoltage_monitor_en(ovmon), .rail_overvoltage(rail_ov),
		.overvoltage_flag(ovflag), .switch3_limit_ma(lim3),
		.switch2_limit_ma(lim2), .switch_misc_cfg(misc), .undervolt_sel(uv),
		.undervolt_hyst_sel(uv_hys)
	);

	task automatic chk(input string nm, input logic [10:0] e,
		input logic [10:0] g);
		n_checks++;
		if (g !== e) begin
			$display("ERROR %s expected %h seen %h", nm, e, g);
			num_errors++;
		end
	endtask

	task automatic results;
		$display("checks %0d mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic rd_exp(input logic [7:0] ad, input logic [7:0] e);
		exp_q.push_back(e);
		host_model_inst.rd(ad);
	endtask

	// Counts falling edges until the watched output rises, bounded
	task automatic measure(input logic sel, input int e);
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (((sel ? breset : pgood) !== 1'b1) && n <= e + 10);
		if (n > e + 10) begin
			$display("ERROR %s expected %0d seen %0d",
				sel ? "button_reset" : "power_good", e, n);
			num_errors++;
			results;
		end
		chk("latency", 11'h001, 11'(n >= e && n <= e + 3));
	endtask

	// Read data lands one edge after the request is taken
	always @(posedge clk) rd_flag <= req.rd_en;
	always @(negedge clk) begin
		if (rd_flag) begin
			if (exp_q.size() == 0) chk("read_queue", 11'h000, 11'h001);
			else chk("rd_data", 11'(exp_q.pop_front()), 11'(rd_data));
		end
	end

	initial begin
		repeat (12) @(negedge clk);
		rst_b = 1'b1;
		rd_exp(8'h13, 8'h00);
		rd_exp(8'h14, 8'h40);
		rd_exp(8'h15, 8'h00);
		rd_exp(8'h10, 8'h00);
		rd_exp(8'h20, 8'h00);
		$display("reset test done");
		host_model_inst.wr(8'h13, 8'hFF);
		chk("write_rejected", 11'h001, 11'(wrej));
		host_model_inst.wr(8'h10, 8'h00);
		host_model_inst.wr(8'h14, 8'h00);
		chk("write_rejected", 11'h001, 11'(wrej));
		// Unlock is spent by any intervening write
		host_model_inst.wr(8'h10, 8'h13 ^ pmic_cfg_pkg::UNLOCK_KEY);
		host_model_inst.wr(8'h20, 8'h55);
		host_model_inst.wr(8'h13, 8'hFF);
		chk("write_rejected", 11'h001, 11'(wrej));
		rd_exp(8'h13, 8'h00);
		rd_exp(8'h14, 8'h40);
		for (int i = 0; i < 6; i++) begin
			v = 8'($random(seed));
			a = 8'h13 + 8'(i % 3);
			host_model_inst.unlock_wr(a, v);
			chk("write_rejected", 11'h000, 11'(wrej));
			case (a)
				8'h13: chk("uv_sel", 11'(v[1:0]), 11'(uv));
				8'h14: chk("uv_hyst", 11'(v[6]), 11'(uv_hys));
				default: chk("misc", 11'(v[5:0]), 11'(misc));
			endcase
			rd_exp(a, v & (a == 8'h13 ? 8'hFF : a == 8'h14 ? 8'hCF : 8'h3F));
		end
		// Unlock must not survive a reset; reads alone do not spend it
		host_model_inst.wr(8'h10, 8'h15 ^ pmic_cfg_pkg::UNLOCK_KEY);
		rst_b = 1'b0;
		repeat (2) @(negedge clk);
		rst_b = 1'b1;
		rd_exp(8'h14, 8'h40);
		rd_exp(8'h15, 8'h00);
		host_model_inst.wr(8'h15, 8'hFF);
		chk("write_rejected", 11'h001, 11'(wrej));
		$display("register test done");
		for (int i = 0; i < 4; i++) begin
			host_model_inst.unlock_wr(8'h14, {4'h0, 2'(i), 2'(3 - i)});
			chk("switch3_limit", lim_tab[i], lim3);
			chk("switch2_limit", lim_tab[3 - i], lim2);
		end
		$display("limit test done");
		host_model_inst.unlock_wr(8'h13, 8'h00);
		host_model_inst.unlock_wr(8'h14, 8'h00);
		rail_ov = 1'b1;
		for (int j = 0; j < 8; j++) begin
			@(negedge clk);
			level_bits = 3'(j);
			#1;
			chk("pin1_oe", 11'(!level_bits[0]), 11'(p1_oe));
			chk("out2_oe", 11'(!level_bits[1]), 11'(o2_oe));
			chk("pin3_oe", 11'(!level_bits[2]), 11'(p3_oe));
			chk("warm_reset", 11'h000, 11'(warm));
			chk("pin1_out", 11'h000, 11'(p1_out));
			chk("out2_out", 11'h000, 11'(o2_out));
			chk("pin3_out", 11'h000, 11'(p3_out));
		end
		chk("out2_push_pull", 11'h000, 11'(o2_hi));
		chk("overvoltage", 11'h000, 11'({tight, ovmon, ovflag}));
		host_model_inst.unlock_wr(8'h13, 8'h64);
		host_model_inst.unlock_wr(8'h14, 8'h80);
		chk("out2_push_pull", 11'h001, 11'(o2_hi));
		chk("overvoltage", 11'h007, 11'({tight, ovmon, ovflag}));
		for (int j = 0; j < 8; j++) begin
			@(negedge clk);
			level_bits = 3'($random(seed));
			pin1_in = j[0];
			pin3_in = j[1];
			#1;
			chk("pin1_oe", 11'h000, 11'(p1_oe));
			chk("out2_oe", 11'h001, 11'(o2_oe));
			chk("out2_out", 11'(pin1_in), 11'(o2_out));
			chk("pin3_oe", 11'h000, 11'(p3_oe));
			chk("warm_reset", 11'(!pin3_in), 11'(warm));
		end
		$display("pin test done");
		for (int i = 0; i < 4; i++) begin
			host_model_inst.unlock_wr(8'h13, {3'h0, 2'(i), 3'h0});
			rails = 1'b1;
			measure(1'b0, dly[i] * T);
			rails = 1'b0;
			@(negedge clk);
			chk("power_good_fall", 11'h000, 11'(pgood));
		end
		$display("power good test done");
		for (int h = 0; h < 2; h++) begin
			host_model_inst.unlock_wr(8'h13, {1'(h), 7'h00});
			button = 1'b1;
			measure(1'b1, (h == 1 ? 15000 : 8000) * T);
			repeat (20) begin
				@(negedge clk);
				chk("button_reset_once", 11'h000, 11'(breset));
			end
			button = 1'b0;
		end
		$display("button test done");
		chk("read_queue_left", 11'h000, 11'(exp_q.size()));
		results;
	end
endmodule
